//--- sfr_defines.svh
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

// ----------------------------------------------------------------
// Block layout on the line
// ----------------------------------------------------------------
`define SFR_BLK_DATA_W  64        // Data bits per block
`define SFR_CRC_W       4         // Check bits after each block
`define SFR_BLK_BITS    68        // Data plus check bits
`define SFR_BLK_PAIRS   6'd34     // Bit pairs per block (two bits per line clock)
`define SFR_PAIR_W      6         // Width of the pair counter
`define SFR_GRP_W       6         // Width of a block index

// ----------------------------------------------------------------
// Check code
// ----------------------------------------------------------------
`define SFR_CRC_POLY    4'h3      // x^4 + x + 1
`define SFR_CRC_INIT    4'hF      // Seed for every block

// ----------------------------------------------------------------
// Status block fields
// ----------------------------------------------------------------
`define SFR_LANES       12        // Receive lanes reported
`define SFR_INTF_BIT    0         // Interface health position
`define SFR_LANE_LSB    1         // Lane health lowest position

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SFR_INTF_RST    1'h0      // Interface unhealthy until told otherwise
`define SFR_LANE_RST    12'h000   // Lanes unhealthy until told otherwise

`endif

//--- sfr_pkg.sv
package sfr_pkg;

    // ------------------------------------------------------------
    // One finished block handed from the line side to the user side
    // ------------------------------------------------------------
    typedef struct packed {
        logic                          is_status; // Status block, not a calendar group
        logic [5:0]                    grp;       // Calendar group number
        logic                          crc_ok;    // Check code matched
        logic [63:0]                   data;      // Block payload, bit 0 sent first
    } sfr_blk_t;

endpackage : sfr_pkg

//--- sfr_sideband_flow_receiver.sv
`timescale 1ns/1ps
`include "sfr_defines.svh"
// What this block does
// - User outputs registered, inputs sampled on user clock
// - Reset synchronised into each domain separately
// - Parameterised per-channel bits, one means transmit
// - Bits beyond received calendar length are don't-care
// - Any unhealthy report forces all channel bits low
// - Bad check code keeps channel bits unchanged
// - Check-code error flag goes high on mismatch
// - No channel or health updates while error flag is high
// - Overflow flag when user clock too slow
// - Interface health shown on one output
// - One health bit per lane, zero halts all
// - Pulse group update bit on good refresh
// - Line data on both clock edges, sync separate
// - Each 64 data bits followed by four check bits
module sfr_sideband_flow_receiver #(
    parameter int MAX_CAL = 128                              // Calendar entries, multiple of 64
) (
    input  wire logic                   i_clk,               // User clock
    input  wire logic                   i_rst_n,             // Reset pin, active low
    input  wire logic                   i_ce,                // User-side clock enable
    input  wire logic                   i_line_clock_in,     // Received line clock
    input  wire logic                   i_line_data_in,      // Received line data, both edges
    input  wire logic                   i_line_sync_in,      // Received frame sync
    output logic [MAX_CAL-1:0]          o_chan_xon_bits,     // Per-channel transmit permission
    output logic                        o_intf_health,       // Remote interface health
    output logic [`SFR_LANES-1:0]       o_lane_health,       // Remote lane health
    output logic                        o_crc_error,         // Last block failed its check
    output logic                        o_overflow,          // A block was dropped
    output logic [MAX_CAL/64-1:0]       o_group_update       // Group refreshed this cycle
);

    localparam int NGRP = MAX_CAL / 64;                      // Calendar groups per frame

    // ------------------------------------------------------------
    // Check code over one block, bit 0 first
    // ------------------------------------------------------------
    function automatic logic [`SFR_CRC_W-1:0] crc_of(input logic [`SFR_BLK_DATA_W-1:0] d);
        logic [`SFR_CRC_W-1:0] c;
        logic                  fb;
        c = `SFR_CRC_INIT;
        for (int i = 0; i < `SFR_BLK_DATA_W; i++) begin
            fb = c[`SFR_CRC_W-1] ^ d[i];
            c  = {c[`SFR_CRC_W-2:0], 1'b0} ^ (fb ? `SFR_CRC_POLY : 4'h0);
        end
        return c;
    endfunction : crc_of

    // ------------------------------------------------------------
    // Line side: reset synchroniser
    // ------------------------------------------------------------
    logic                       l_rst_s1_r;                  // First stage
    logic                       l_rst_s2_r;                  // Line-side reset, active low

    // Only advances while the far end runs its clock, hence the hold time on reset
    always_ff @(posedge i_line_clock_in) begin
        l_rst_s1_r <= i_rst_n;
        l_rst_s2_r <= l_rst_s1_r;
    end

    // ------------------------------------------------------------
    // Line side: double-rate capture
    // ------------------------------------------------------------
    logic                       rise_bit_r;                  // Bit taken on rising edge
    logic                       fall_bit_r;                  // Bit taken on falling edge
    logic                       rise_sync_r;                 // Sync taken with rising bit

    // Falling half of each pair
    always_ff @(negedge i_line_clock_in) begin
        fall_bit_r <= i_line_data_in;
    end

    // Rising half of each pair and its sync
    always_ff @(posedge i_line_clock_in) begin
        rise_bit_r  <= i_line_data_in;
        rise_sync_r <= i_line_sync_in;
    end

    // ------------------------------------------------------------
    // Line side: framing into blocks
    // ------------------------------------------------------------
    logic [`SFR_BLK_BITS-1:0]   shift_r;                     // Block being assembled
    logic [`SFR_BLK_BITS-1:0]   shift_nxt;                   // With the newest pair
    logic [`SFR_PAIR_W-1:0]     pair_cnt_r;                  // Pairs taken in this block
    logic [`SFR_GRP_W-1:0]      blk_idx_r;                   // 0 is status, then groups
    logic                       frame_on_r;                  // Inside a frame
    logic                       blk_done;                    // Block complete this edge
    logic                       crc_good;                    // Check code matches

    // Earlier bit lands lower, so bit 0 ends up at the bottom
    assign shift_nxt = {fall_bit_r, rise_bit_r, shift_r[`SFR_BLK_BITS-1:2]};
    assign blk_done  = frame_on_r && !rise_sync_r && (pair_cnt_r == `SFR_BLK_PAIRS - 6'd1);
    assign crc_good  = (crc_of(shift_nxt[`SFR_BLK_DATA_W-1:0])
                        == shift_nxt[`SFR_BLK_BITS-1:`SFR_BLK_DATA_W]);

    // Sync restarts the frame at any point; a frame is status then all groups
    always_ff @(posedge i_line_clock_in) begin
        if (!l_rst_s2_r) begin
            shift_r    <= '0;
            pair_cnt_r <= '0;
            blk_idx_r  <= '0;
            frame_on_r <= 1'b0;
        end else if (rise_sync_r) begin
            shift_r    <= shift_nxt;
            pair_cnt_r <= `SFR_PAIR_W'(1);
            blk_idx_r  <= '0;
            frame_on_r <= 1'b1;
        end else if (frame_on_r) begin
            shift_r <= shift_nxt;
            if (blk_done) begin
                pair_cnt_r <= '0;
                blk_idx_r  <= blk_idx_r + `SFR_GRP_W'(1);
                if (blk_idx_r == `SFR_GRP_W'(NGRP)) begin
                    frame_on_r <= 1'b0;                      // Wait for next sync
                end
            end else begin
                pair_cnt_r <= pair_cnt_r + `SFR_PAIR_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Line side: one-entry hand-over with toggle handshake
    // ------------------------------------------------------------
    sfr_pkg::sfr_blk_t          hold_r;                      // Block waiting for user side
    logic                       req_r;                       // Toggles when hold is filled
    logic                       ack_s1_r;                    // Ack first stage
    logic                       ack_s2_r;                    // Ack usable on line side
    logic                       ovf_tgl_r;                   // Toggles per drop not yet seen
    logic                       hold_free;                   // User side took the last one
    logic                       ack_r;                       // User-side ack toggle
    logic                       ovf_ack_s1_r;                // Drop ack first stage
    logic                       ovf_ack_s2_r;                // Drop ack usable on line side
    logic                       ovf_s3_r;                    // Drop toggle last seen by user side

    assign hold_free = (req_r == ack_s2_r);

    // Hand-over ack and drop ack back into line domain
    always_ff @(posedge i_line_clock_in) begin
        if (!l_rst_s2_r) begin
            ack_s1_r     <= 1'b0;
            ack_s2_r     <= 1'b0;
            ovf_ack_s1_r <= 1'b0;
            ovf_ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r     <= ack_r;
            ack_s2_r     <= ack_s1_r;
            ovf_ack_s1_r <= ovf_s3_r;
            ovf_ack_s2_r <= ovf_ack_s1_r;
        end
    end

    // Hold stays still until acked, so the user side may read it directly
    always_ff @(posedge i_line_clock_in) begin
        if (!l_rst_s2_r) begin
            hold_r    <= '0;
            req_r     <= 1'b0;
            ovf_tgl_r <= 1'b0;
        end else if (blk_done && (blk_idx_r <= `SFR_GRP_W'(NGRP))) begin
            if (hold_free) begin
                hold_r.is_status <= (blk_idx_r == '0);
                hold_r.grp       <= blk_idx_r - `SFR_GRP_W'(1);
                hold_r.crc_ok    <= crc_good;
                hold_r.data      <= shift_nxt[`SFR_BLK_DATA_W-1:0];
                req_r            <= ~req_r;
            end else if (ovf_tgl_r == ovf_ack_s2_r) begin
                // Later drops merge until this one is seen, so an even count cannot vanish
                ovf_tgl_r <= ~ovf_tgl_r;
            end
        end
    end

    // ------------------------------------------------------------
    // User side: reset and toggle synchronisers
    // ------------------------------------------------------------
    logic                       u_rst_s1_r;                  // First stage
    logic                       u_rst_s2_r;                  // User-side reset, active low
    logic                       req_s1_r;                    // Request first stage
    logic                       req_s2_r;                    // Request usable
    logic                       ovf_s1_r;                    // Overflow first stage
    logic                       ovf_s2_r;                    // Overflow usable

    // Frozen with the clock enable like all user-side state
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            u_rst_s1_r <= i_rst_n;
            u_rst_s2_r <= u_rst_s1_r;
        end
    end

    // Crossings into the user domain
    always_ff @(posedge i_clk) begin
        if (!u_rst_s2_r) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            ovf_s1_r <= 1'b0;
            ovf_s2_r <= 1'b0;
            ovf_s3_r <= 1'b0;
        end else if (i_ce) begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            ovf_s1_r <= ovf_tgl_r;
            ovf_s2_r <= ovf_s1_r;
            ovf_s3_r <= ovf_s2_r;
        end
    end

    // ------------------------------------------------------------
    // User side: take a block and work out next outputs
    // ------------------------------------------------------------
    logic                       take;                        // New block accepted now
    logic                       good;                        // Accepted and check passed
    logic                       intf_nxt;                    // Next interface health
    logic [`SFR_LANES-1:0]      lane_nxt;                    // Next lane health
    logic [MAX_CAL-1:0]         fc_nxt;                      // Next stored channel bits
    logic [NGRP-1:0]            upd_nxt;                     // Next group update pulses
    logic [63:0]                store_r [NGRP];              // Stored calendar groups

    assign take = u_rst_s2_r && i_ce && (req_s2_r != ack_r);
    assign good = take && hold_r.crc_ok;

    // Ack toggles once per block taken
    always_ff @(posedge i_clk) begin
        if (!u_rst_s2_r) begin
            ack_r <= 1'b0;
        end else if (take) begin
            ack_r <= req_s2_r;
        end
    end

    // Health only changes on a good status block
    always_comb begin
        intf_nxt = o_intf_health;
        lane_nxt = o_lane_health;
        if (good && hold_r.is_status) begin
            intf_nxt = hold_r.data[`SFR_INTF_BIT];
            lane_nxt = hold_r.data[`SFR_LANE_LSB +: `SFR_LANES];
        end
    end

    // One store and one update bit per calendar group
    genvar g;
    for (g = 0; g < NGRP; g++) begin : g_grp
        assign upd_nxt[g]          = good && !hold_r.is_status
                                     && (hold_r.grp == `SFR_GRP_W'(g));
        assign fc_nxt[g*64 +: 64]  = upd_nxt[g] ? hold_r.data : store_r[g];

        // Failed blocks never reach the store
        always_ff @(posedge i_clk) begin
            if (!u_rst_s2_r) begin
                store_r[g] <= '0;
            end else if (i_ce) begin
                store_r[g] <= fc_nxt[g*64 +: 64];
            end
        end
    end

    // ------------------------------------------------------------
    // User side: output registers
    // ------------------------------------------------------------
    // All outputs come from flops on the user clock
    always_ff @(posedge i_clk) begin
        if (!u_rst_s2_r) begin
            o_chan_xon_bits <= '0;
            o_intf_health   <= `SFR_INTF_RST;
            o_lane_health   <= `SFR_LANE_RST;
            o_group_update  <= '0;
        end else if (i_ce) begin
            o_intf_health  <= intf_nxt;
            o_lane_health  <= lane_nxt;
            o_group_update <= upd_nxt;
            // Upper bits past a short calendar simply keep old values
            if (!intf_nxt || !(&lane_nxt)) begin
                o_chan_xon_bits <= '0;
            end else begin
                o_chan_xon_bits <= fc_nxt;
            end
        end
    end

    // Error flag follows the last block taken
    always_ff @(posedge i_clk) begin
        if (!u_rst_s2_r) begin
            o_crc_error <= 1'b0;
        end else if (take) begin
            o_crc_error <= !hold_r.crc_ok;
        end
    end

    // One pulse per drop toggle; drops made before the last one is acked share one pulse
    always_ff @(posedge i_clk) begin
        if (!u_rst_s2_r) begin
            o_overflow <= 1'b0;
        end else if (i_ce) begin
            o_overflow <= (ovf_s2_r != ovf_s3_r);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_bad_take;
        take && !hold_r.crc_ok;
    endsequence

    sequence s_held_outputs;
        $stable(o_chan_xon_bits) && $stable(o_intf_health) && $stable(o_lane_health);
    endsequence

    property p_unhealthy_halt;
        @(posedge i_clk) disable iff (!u_rst_s2_r)
        (!o_intf_health || !(&o_lane_health)) |-> (o_chan_xon_bits == '0);
    endproperty
    a_unhealthy_halt: assert property (p_unhealthy_halt)
        else $error("channel bits not halted while unhealthy");

    property p_bad_holds;
        @(posedge i_clk) disable iff (!u_rst_s2_r)
        s_bad_take |=> s_held_outputs;
    endproperty
    a_bad_holds: assert property (p_bad_holds)
        else $error("outputs changed after a failed block");

    property p_bad_flags;
        @(posedge i_clk) disable iff (!u_rst_s2_r)
        s_bad_take |=> o_crc_error && (o_group_update == '0);
    endproperty
    a_bad_flags: assert property (p_bad_flags)
        else $error("error flag missing after a failed block");

    property p_update_good;
        @(posedge i_clk) disable iff (!u_rst_s2_r)
        (o_group_update != '0) |-> !o_crc_error && $past(good);
    endproperty
    a_update_good: assert property (p_update_good)
        else $error("group update without a good block");

    property p_intf_source;
        @(posedge i_clk) disable iff (!u_rst_s2_r)
        $changed(o_intf_health) |-> $past(good && hold_r.is_status);
    endproperty
    a_intf_source: assert property (p_intf_source)
        else $error("interface health changed without status block");

    property p_lane_load;
        @(posedge i_clk) disable iff (!u_rst_s2_r)
        good && hold_r.is_status |=> o_lane_health == $past(hold_r.data[`SFR_LANES:1]);
    endproperty
    a_lane_load: assert property (p_lane_load)
        else $error("lane health not loaded from status block");

    property p_ovf_flag;
        @(posedge i_clk) disable iff (!u_rst_s2_r)
        i_ce && (ovf_s2_r != ovf_s3_r) |=> o_overflow;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("dropped block not flagged");

    property p_drop_on_busy;
        @(posedge i_line_clock_in) disable iff (!l_rst_s2_r)
        blk_done && !hold_free && (blk_idx_r <= `SFR_GRP_W'(NGRP))
        |=> (ovf_tgl_r != $past(ovf_ack_s2_r)) && $stable(req_r);
    endproperty
    a_drop_on_busy: assert property (p_drop_on_busy)
        else $error("busy hand-over did not drop the block");

endmodule : sfr_sideband_flow_receiver

//--- sfr_line_tx_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far-end line transmitter model
// ------------------------------------------------------------
module sfr_line_tx_model (
    input  wire logic             i_go,         // Send one frame while high
    input  wire logic [2:0][63:0] i_blk,        // Status, group 0, group 1
    input  wire logic [2:0]       i_bad,        // Corrupt check code per block
    output logic                  o_done,       // Frame sent, waits for go low
    output logic                  o_line_clock, // Line clock, still between frames
    output logic                  o_data,       // Line data, both edges
    output logic                  o_sync        // Frame sync
);
    logic [67:0] bits;                          // One block with check code
    logic [3:0]  crc;                           // Running check code

    // One pair: A before the rising edge, B before the falling one
    task automatic pair(input logic a, input logic b, input logic s);
        o_data = a;
        o_sync = s;
        #8 o_line_clock = 1'b1;
        #8 o_data = b;
        o_sync = 1'b0;
        #8 o_line_clock = 1'b0;
        #8;
    endtask : pair

    // Frame loop; warm-up edges let the line-side reset settle
    initial begin
        o_done = 1'b0;
        o_line_clock = 1'b0;
        o_data = 1'b0;
        o_sync = 1'b0;
        forever begin
            wait (i_go === 1'b1);
            repeat (20) pair(~o_data, o_data, 1'b0);
            for (int b = 0; b < 3; b++) begin
                crc = 4'hF;
                for (int i = 0; i < 64; i++)
                    crc = {crc[2:0], 1'b0} ^ ((crc[3] ^ i_blk[b][i]) ? 4'h3 : 4'h0);
                bits = {crc ^ {3'h0, i_bad[b]}, i_blk[b]};
                for (int p = 0; p < 34; p++)
                    pair(bits[2*p], bits[2*p+1], (b == 0 && p == 0));
            end
            repeat (4) pair(~o_data, o_data, 1'b0);
            // Idle line shows the inverse of the last bit, never a stale value
            o_data = ~o_data;
            o_done = 1'b1;
            wait (i_go === 1'b0);
            o_done = 1'b0;
        end
    end
endmodule : sfr_line_tx_model

//--- tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench for the sideband flow receiver
// ------------------------------------------------------------
module tb;
    localparam logic [3:0][2:0] CORNER = 12'hF08; // Bad masks 000 001 100 111
    logic             i_clk;           // User clock
    logic             i_rst_n;         // Reset, active low
    logic             i_ce;            // User clock enable
    logic             go;              // Frame request
    logic [2:0][63:0] blk;             // Frame payloads
    logic [2:0]       bad;             // Corrupt check per block
    logic             done;            // Far end finished
    logic             lclk;            // Line clock
    logic             ldata;           // Line data
    logic             lsync;           // Line sync
    logic [127:0]     chan;            // Channel bits
    logic             intf;            // Interface health
    logic [11:0]      lane;            // Lane health
    logic             crc_err;         // Check error flag
    logic             ovf;             // Overflow pulse
    logic [1:0]       upd;             // Group update pulses
    logic [1:0]       upd_seen;        // Updates since launch
    logic             ovf_seen;        // Overflow since launch
    logic             crc_seen;        // Error flag since launch
    logic [1:0][63:0] e_grp;           // Expected stored groups
    logic             e_intf;          // Expected interface health
    logic [11:0]      e_lane;          // Expected lane health
    logic             e_crc;           // Expected error flag level
    int               error_cnt;       // Mismatches
    int               samples_checked; // Comparisons

    sfr_sideband_flow_receiver #(.MAX_CAL(128)) sfr_sideband_flow_receiver_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_line_clock_in(lclk),
        .i_line_data_in(ldata), .i_line_sync_in(lsync), .o_chan_xon_bits(chan),
        .o_intf_health(intf), .o_lane_health(lane), .o_crc_error(crc_err),
        .o_overflow(ovf), .o_group_update(upd));

    sfr_line_tx_model sfr_line_tx_model_i (
        .i_go(go), .i_blk(blk), .i_bad(bad), .o_done(done),
        .o_line_clock(lclk), .o_data(ldata), .o_sync(lsync));

    // User clock, 40 ns
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Catch one-cycle pulses between launch and check; cleared in reset
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            upd_seen <= 2'b00;
            ovf_seen <= 1'b0;
            crc_seen <= 1'b0;
        end else begin
            upd_seen <= upd_seen | upd;
            ovf_seen <= ovf_seen | ovf;
            crc_seen <= crc_seen | crc_err;
        end
    end

    // Channel bits the rules ask for, given health and stored groups
    function automatic logic [127:0] exp_chan(input logic h, input logic [11:0] l, input logic [127:0] g);
        return (h && &l) ? g : 128'h0;
    endfunction : exp_chan

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Random frame; starving stops the user side so later blocks drop
    task automatic launch(input logic [2:0] bd, input logic starve);
        blk = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        blk[0][0] = ($urandom % 4) != 0;
        blk[0][12:1] = ($urandom % 3 == 0) ? 12'($urandom) : 12'hFFF;
        bad = bd;
        i_ce = ~starve;
        upd_seen = 2'b00;
        ovf_seen = 1'b0;
        crc_seen = 1'b0;
        go = 1'b1;
    endtask : launch

    // Wait for the frame, then compare against the stored expectation
    task automatic finish(input logic starve);
        logic [1:0] e_upd;
        logic [2:0] use_blk;
        e_upd = 2'b00;
        use_blk = starve ? 3'b001 : ~bad;
        for (int n = 0; n < 400 && done !== 1'b1; n++)
            @(negedge i_clk);
        check(done, 1'b1);
        go = 1'b0;
        @(negedge i_clk);
        i_ce = 1'b1;
        repeat (12) @(negedge i_clk);
        if (use_blk[0]) begin
            e_intf = blk[0][0];
            e_lane = blk[0][12:1];
        end
        for (int g = 0; g < 2; g++)
            if (use_blk[g+1]) begin
                e_grp[g] = blk[g+1];
                e_upd[g] = 1'b1;
            end
        check(chan, exp_chan(e_intf, e_lane, e_grp));
        check(intf, e_intf);
        check(lane, e_lane);
        check(crc_err, bad[starve ? 0 : 2]);
        check(crc_seen, e_crc | (|bad));
        e_crc = bad[starve ? 0 : 2];
        check(upd_seen, e_upd);
        check(ovf_seen, starve);
    endtask : finish

    // Hang guard
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    // Main sequence; first frame starts during reset to warm the line side
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        e_grp = '0;
        e_intf = 1'b0;
        e_lane = 12'h000;
        e_crc = 1'b0;
        i_rst_n = 1'b0;
        void'($urandom(32'h42CF2B78));
        launch(3'b000, 1'b0);
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        check(chan, 128'h0);
        check({intf, lane, crc_err, ovf, upd}, 17'h0);
        finish(1'b0);
        for (int k = 0; k < 10; k++) begin
            @(negedge i_clk);
            launch(k < 4 ? CORNER[k] : 3'($urandom), 1'b0);
            finish(1'b0);
        end
        @(negedge i_clk);
        launch(3'b000, 1'b1);
        finish(1'b1);
        @(negedge i_clk);
        launch(3'b000, 1'b0);
        finish(1'b0);
        report_and_stop();
    end
endmodule : tb
